// ===== hw/i2c_bus_timeout_status.v
// Bus timeout detection and status flags of a two-wire interface.
// Assumes scl_i, sda_i and alarm_pin_i come from pins (asynchronous);
// match, stretch and PEC inputs come from logic on clk_i.
//
// The address-and-strobe port is this design's own decision.
`include "i2c_tmo_consts.vh"

module i2c_bus_timeout_status #(
    parameter SMBUS_SUPPORT = 1
) (
    input wire clk_i, // Kernel clock, 100 MHz
    input wire rst_n_i, // Asynchronous reset, active low
    input wire ce_i, // Clock enable, freezes all state when low
    input wire [7:0] addr_i, // Register byte address
    input wire [31:0] wdata_i, // Register write data
    input wire wr_i, // Write strobe
    input wire rd_i, // Read strobe
    output reg [31:0] rdata_o, // Read data, cycle after rd_i
    input wire scl_i, // Clock line level
    input wire sda_i, // Data line level
    input wire alarm_pin_i, // Alarm line level
    input wire controller_mode_i, // High in controller role
    input wire stretching_i, // High while this end holds SCL low
    input wire addr_match_i, // One-cycle pulse on address match
    input wire [6:0] rx_addr_code_i, // Received 7-bit address
    input wire ten_bit_i, // Match was on a 10-bit address
    input wire [1:0] rx_addr_top_i, // Bits 9:8 of 10-bit address
    input wire rx_dir_i, // Received direction bit
    input wire pec_check_i, // Pulse when PEC byte received
    input wire [7:0] pec_rx_i, // Received PEC byte
    input wire [7:0] pec_calc_i, // Computed PEC value
    output reg pec_nack_o, // Pulse: answer the PEC byte with NACK
    output wire bus_limit_error_o, // Timeout flag level
    output wire peripheral_enable_o // Enable bit to the rest of block
);

    localparam CW = 25;

    // Condition counter: fires once held longer than the limit
    // Units of 4 or 2048 cycles built by shifting, so no bits are lost
    function [CW-1:0] lim_a;
        input idle;
        input [11:0] field;
        reg [12:0] units;
        begin
            units = {1'b0, field} + 13'h0001;
            if (idle) begin
                lim_a = {10'h000, units, 2'h0};
            end else begin
                lim_a = {1'b0, units, 11'h000};
            end
        end
    endfunction

    reg [2:0] scl_sync_q;
    reg [2:0] sda_sync_q;
    reg [2:0] alm_sync_q;
    reg scl_q;
    reg sda_q;
    reg alm_q;
    reg scl_prev_q;
    reg sda_prev_q;
    reg alm_prev_q;

    reg [2:0] control_q;
    reg [31:0] cfg_q;
    reg [6:0] code_q;
    reg dir_q;
    reg busy_q;
    reg alert_q;
    reg tmo_q;
    reg pec_err_q;
    reg [CW-1:0] a_cnt_q;
    reg [CW-1:0] b_cnt_q;
    reg a_role_q;
    reg [31:0] rdata_d;

    wire pe;
    wire host_en;
    wire alarm_en;
    wire ext_en;
    wire clk_en;
    wire idle_sel;
    wire [11:0] field_a;
    wire [11:0] field_b;
    wire [CW-1:0] limit_a;
    wire [CW-1:0] limit_b;
    wire [12:0] b_units;
    wire a_cond;
    wire a_fire;
    wire b_fire;
    wire start_det;
    wire stop_det;
    wire alarm_fall;
    wire pec_bad;
    wire wr_cfg;
    wire wr_clr;
    wire smb;

    assign smb = (SMBUS_SUPPORT != 0);
    assign pe = control_q[`CTL_PE_BIT];
    assign host_en = control_q[`CTL_HOST_BIT];
    assign alarm_en = control_q[`CTL_ALARM_EN_BIT];
    assign ext_en = cfg_q[`CFG_EXT_EN_BIT];
    assign clk_en = cfg_q[`CFG_CLK_EN_BIT];
    assign idle_sel = cfg_q[`CFG_IDLE_SEL_BIT];
    assign field_a = cfg_q[`CFG_LIM_A_HI:`CFG_LIM_A_LO];
    assign field_b = cfg_q[`CFG_LIM_B_HI:`CFG_LIM_B_LO];
    assign peripheral_enable_o = pe;
    assign bus_limit_error_o = tmo_q;

    assign wr_cfg = wr_i && (addr_i == `OFS_TIMEOUT_CFG);
    assign wr_clr = wr_i && (addr_i == `OFS_FLAG_CLEAR);

    // Pin synchronisers: three stages, accept once stages two and three agree
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            alm_sync_q <= 3'h7;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            alm_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
            alm_prev_q <= 1'b1;
        end else if (ce_i) begin
            scl_sync_q <= {scl_sync_q[1:0], scl_i};
            sda_sync_q <= {sda_sync_q[1:0], sda_i};
            alm_sync_q <= {alm_sync_q[1:0], alarm_pin_i};
            if (scl_sync_q[1] == scl_sync_q[2]) begin
                scl_q <= scl_sync_q[2];
            end
            if (sda_sync_q[1] == sda_sync_q[2]) begin
                sda_q <= sda_sync_q[2];
            end
            if (alm_sync_q[1] == alm_sync_q[2]) begin
                alm_q <= alm_sync_q[2];
            end
            scl_prev_q <= scl_q;
            sda_prev_q <= sda_q;
            alm_prev_q <= alm_q;
        end
    end

    // Bus conditions seen on the filtered lines
    assign start_det = scl_q && scl_prev_q && sda_prev_q && !sda_q;
    assign stop_det = scl_q && scl_prev_q && !sda_prev_q && sda_q;
    assign alarm_fall = alm_prev_q && !alm_q;

    // Limit A: SCL low or bus idle depending on idle select
    assign limit_a = lim_a(idle_sel, field_a); // see R7 see R8
    assign a_cond = idle_sel ? (scl_q && sda_q) : !scl_q; // see R5
    assign b_units = {1'b0, field_b} + 13'h0001;
    assign limit_b = {1'b0, b_units, 11'h000}; // see R2

    assign a_fire = smb && pe && clk_en && a_cond
        && (a_cnt_q == limit_a); // see R4
    assign b_fire = smb && pe && ext_en && stretching_i
        && (b_cnt_q == limit_b); // see R1

    assign pec_bad = pec_check_i && (pec_rx_i != pec_calc_i);

    // Low or idle counter
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a_cnt_q <= {CW{1'b0}};
            a_role_q <= 1'b0;
        end else if (ce_i) begin
            a_role_q <= idle_sel;
            if (!pe || !clk_en || !a_cond || (a_role_q != idle_sel)) begin
                a_cnt_q <= {CW{1'b0}}; // see R20
            end else if (a_cnt_q <= limit_a) begin
                a_cnt_q <= a_cnt_q + 25'h0000001;
            end
        end
    end

    // Cumulative stretch counter, one transfer at a time
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            b_cnt_q <= {CW{1'b0}};
        end else if (ce_i) begin
            if (!pe || !ext_en || stop_det || start_det) begin
                b_cnt_q <= {CW{1'b0}}; // see R20
            end else if (stretching_i && (b_cnt_q <= limit_b)) begin
                b_cnt_q <= b_cnt_q + 25'h0000001; // see R2
            end
        end
    end

    // Control and timeout configuration
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            control_q <= 3'h0;
            cfg_q <= `CFG_RESET;
        end else if (ce_i) begin
            if (wr_i && (addr_i == `OFS_CONTROL)) begin
                control_q <= wdata_i[2:0];
            end
            // Writes land in one cycle, so none is ever pending
            if (wr_cfg && smb) begin // see R10 see R11
                cfg_q[`CFG_EXT_EN_BIT] <= wdata_i[`CFG_EXT_EN_BIT];
                cfg_q[`CFG_CLK_EN_BIT] <= wdata_i[`CFG_CLK_EN_BIT];
                if (!ext_en) begin
                    cfg_q[`CFG_LIM_B_HI:`CFG_LIM_B_LO] <=
                        wdata_i[`CFG_LIM_B_HI:`CFG_LIM_B_LO]; // see R3
                end
                if (!clk_en) begin
                    cfg_q[`CFG_IDLE_SEL_BIT] <=
                        wdata_i[`CFG_IDLE_SEL_BIT]; // see R6
                    cfg_q[`CFG_LIM_A_HI:`CFG_LIM_A_LO] <=
                        wdata_i[`CFG_LIM_A_HI:`CFG_LIM_A_LO]; // see R9
                end
            end
        end
    end

    // Address code and direction
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_q <= 7'h00;
            dir_q <= 1'b0;
        end else if (ce_i) begin
            if (addr_match_i) begin
                if (ten_bit_i) begin
                    code_q <= {`TEN_BIT_HEADER, rx_addr_top_i}; // see R13
                end else begin
                    code_q <= rx_addr_code_i; // see R12
                end
                dir_q <= rx_dir_i; // see R14
            end
        end
    end

    // Bus busy
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 1'b0;
        end else if (ce_i) begin
            if (!pe || stop_det) begin
                busy_q <= 1'b0; // see R15
            end else if (start_det) begin
                busy_q <= 1'b1; // see R15
            end
        end
    end

    // Sticky SMBus flags: a set in the clearing cycle wins
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alert_q <= 1'b0;
            tmo_q <= 1'b0;
            pec_err_q <= 1'b0;
        end else if (ce_i) begin
            if (!pe || !smb) begin
                alert_q <= 1'b0; // see R19
                tmo_q <= 1'b0; // see R17
                pec_err_q <= 1'b0;
            end else begin
                if (host_en && alarm_en && alarm_fall) begin
                    alert_q <= 1'b1; // see R16
                end else if (wr_clr && wdata_i[`CLR_ALERT_BIT]) begin
                    alert_q <= 1'b0; // see R16
                end
                if (a_fire || b_fire) begin
                    tmo_q <= 1'b1; // see R17
                end else if (wr_clr && wdata_i[`CLR_TMO_BIT]) begin
                    tmo_q <= 1'b0; // see R17
                end
                if (pec_bad) begin
                    pec_err_q <= 1'b1; // see R18
                end else if (wr_clr && wdata_i[`CLR_PEC_BIT]) begin
                    pec_err_q <= 1'b0; // see R18
                end
            end
        end
    end

    // PEC mismatch answered with NACK
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pec_nack_o <= 1'b0;
        end else if (ce_i) begin
            pec_nack_o <= pe && smb && pec_bad; // see R18
        end
    end

    // Read mux
    always @* begin
        rdata_d = 32'h00000000;
        case (addr_i)
            `OFS_CONTROL: begin
                rdata_d[2:0] = control_q;
            end
            `OFS_TIMEOUT_CFG: begin
                rdata_d = smb ? cfg_q : 32'h00000000; // see R10
            end
            `OFS_STATUS: begin
                rdata_d = `ST_RESET;
                rdata_d[`ST_CODE_HI:`ST_CODE_LO] = code_q;
                rdata_d[`ST_DIR_BIT] = dir_q;
                rdata_d[`ST_BUSY_BIT] = busy_q;
                rdata_d[`ST_ALERT_BIT] = alert_q; // see R19
                rdata_d[`ST_TMO_BIT] = tmo_q;
                rdata_d[`ST_PEC_BIT] = pec_err_q;
            end
            default: begin
                rdata_d = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h00000000;
        end else if (ce_i) begin
            if (rd_i) begin
                rdata_o <= rdata_d;
            end else begin
                rdata_o <= 32'h00000000;
            end
        end
    end

endmodule // i2c_bus_timeout_status

// ===== hw/i2c_tmo_consts.vh
// Constants for the bus timeout and status block.
// Assumes a 100 MHz kernel clock and the plain register port.
// Overview of operation
// (R1) Extended enable on: cumulative own stretch past limit raises timeout.
// (R2) Stretch limit is (field plus 1) times 2048 cycles, either role.
// (R3) Stretch limit field writable only while extended detection is off.
// (R4) Clock detection on: SCL low or bus idle past limit raises timeout.
// (R5) Idle select 0 watches SCL low; 1 watches SCL and SDA high.
// (R6) Idle select writable only while clock detection is off.
// (R7) Low limit is (field A plus 1) times 2048 cycles.
// (R8) Idle limit is (field A plus 1) times 4 cycles.
// (R9) Field A writable only while clock detection is off.
// (R10) Without SMBus the timeout config reads zero and ignores writes.
// (R11) Overlapping config writes wait until the earlier write completes.
// (R12) Address match captures the received 7-bit address code.
// (R13) Ten-bit match captures header pattern plus two top address bits.
// (R14) Address match updates direction: 0 target receives, 1 transmits.
// (R15) Busy sets on START, clears on STOP or when disabled.
// (R16) Alert sets on alarm pin fall with host and detect enabled.
// (R17) Timeout flag sets on any timeout; clears by clear bit or disable.
// (R18) PEC mismatch sets error flag and NACKs; clear bit clears it.
// (R19) Without SMBus alert, timeout and PEC error read zero.
// (R20) Low/idle counter restarts when condition ends, stretch counter on START or STOP; held clear when off.
`ifndef I2C_TMO_CONSTS_VH
`define I2C_TMO_CONSTS_VH

`define OFS_CONTROL 8'h00
`define OFS_TIMEOUT_CFG 8'h14
`define OFS_STATUS 8'h18
`define OFS_FLAG_CLEAR 8'h1C

`define CTL_PE_BIT 0
`define CTL_HOST_BIT 1
`define CTL_ALARM_EN_BIT 2

`define CFG_EXT_EN_BIT 31
`define CFG_LIM_B_HI 27
`define CFG_LIM_B_LO 16
`define CFG_CLK_EN_BIT 15
`define CFG_IDLE_SEL_BIT 12
`define CFG_LIM_A_HI 11
`define CFG_LIM_A_LO 0
`define CFG_RESET 32'h00000000

`define ST_CODE_HI 23
`define ST_CODE_LO 17
`define ST_DIR_BIT 16
`define ST_BUSY_BIT 15
`define ST_ALERT_BIT 13
`define ST_TMO_BIT 12
`define ST_PEC_BIT 11
`define ST_RESET 32'h00000001

`define CLR_PEC_BIT 11
`define CLR_TMO_BIT 12
`define CLR_ALERT_BIT 13

`define LOW_UNIT 2048
`define IDLE_UNIT 4
`define EXT_UNIT 2048
`define TEN_BIT_HEADER 5'h1E

`endif

// ===== verification/i2c_bus_partner.sv
// Far side of the two-wire bus: drives SCL, SDA and the alarm line.
// Assumes pulled-up lines, so a released line reads high.
module i2c_bus_partner;
    timeunit 1ns;
    timeprecision 1ps;
    logic scl = 1'h1;
    logic sda = 1'h1;
    logic alarm = 1'h1;
    // Half period of the 80 ns link clock
    task automatic start_cond();
        sda = 1'h0;
        #40 scl = 1'h0;
        #40;
    endtask
    task automatic stop_cond();
        sda = 1'h0;
        #40 scl = 1'h1;
        #40 sda = 1'h1;
        #40;
    endtask
    // SCL held low for n kernel cycles
    task automatic hold_low(input int n);
        scl = 1'h0;
        #(n * 10) scl = 1'h1;
    endtask
    task automatic alarm_pulse();
        alarm = 1'h0;
        #400 alarm = 1'h1;
    endtask
endmodule // i2c_bus_partner

// ===== verification/i2c_bus_timeout_status_checker.sv
// Port checker for the bus timeout and status block.
// Assumes registered read data and a one-cycle NACK pulse.
module i2c_bus_timeout_status_checker (
    input wire clk_i, // Clock
    input wire rst_n_i, // Reset
    input wire ce_i, // Clock enable
    input wire [7:0] addr_i, // Address
    input wire [31:0] wdata_i, // Write data
    input wire wr_i, // Write
    input wire rd_i, // Read
    input wire [31:0] rdata_o, // Read data
    input wire pec_check_i, // PEC compare
    input wire [7:0] pec_rx_i, // PEC seen
    input wire [7:0] pec_calc_i, // PEC made
    input wire pec_nack_o, // NACK pulse
    input wire bus_limit_error_o, // Timeout flag
    input wire peripheral_enable_o // Enable
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_nack;
        pec_check_i && ce_i && peripheral_enable_o
            && pec_rx_i != pec_calc_i |=> pec_nack_o;
    endproperty
    a_nack: assert property (p_nack) else $error("no nack");
    property p_ack;
        pec_check_i && ce_i && pec_rx_i == pec_calc_i |=> !pec_nack_o;
    endproperty
    a_ack: assert property (p_ack) else $error("bad nack");
    property p_src;
        pec_nack_o |-> $past(pec_check_i)
            && $past(pec_rx_i) != $past(pec_calc_i);
    endproperty
    a_src: assert property (p_src) else $error("stray nack");
    property p_pe;
        wr_i && ce_i && addr_i == 8'h00
            |=> peripheral_enable_o == $past(wdata_i[0]);
    endproperty
    a_pe: assert property (p_pe) else $error("enable lost");
    property p_off;
        !peripheral_enable_o |=> !bus_limit_error_o;
    endproperty
    a_off: assert property (p_off) else $error("flag while off");
    property p_rise;
        $rose(bus_limit_error_o) |-> $past(peripheral_enable_o);
    endproperty
    a_rise: assert property (p_rise) else $error("count while off");
    property p_hold;
        bus_limit_error_o && peripheral_enable_o && ce_i && !wr_i
            |=> bus_limit_error_o;
    endproperty
    a_hold: assert property (p_hold) else $error("flag dropped");
    property p_st;
        rd_i && ce_i && addr_i == 8'h18
            |=> rdata_o[12] == $past(bus_limit_error_o) && rdata_o[0];
    endproperty
    a_st: assert property (p_st) else $error("status differs");
    c_nack: cover property (pec_nack_o);
    c_rise: cover property ($rose(bus_limit_error_o));
    c_fall: cover property ($fell(bus_limit_error_o) && peripheral_enable_o);
endmodule // i2c_bus_timeout_status_checker

bind i2c_bus_timeout_status i2c_bus_timeout_status_checker
    i2c_bus_timeout_status_checker_i (.clk_i, .rst_n_i, .ce_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .pec_check_i, .pec_rx_i, .pec_calc_i,
    .pec_nack_o, .bus_limit_error_o, .peripheral_enable_o);

// ===== verification/i2c_bus_timeout_status_bench.sv
// Self-checking bench for the bus timeout and status block.
// Assumes the partner model on the pins and the bound checker.
module i2c_bus_timeout_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'h0, rst_n_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
    logic controller_mode_i = 1'h0, stretching_i = 1'h0, dir = 1'h0;
    logic addr_match_i = 1'h0, ten_bit_i = 1'h0, rx_dir_i = 1'h0;
    logic pec_check_i = 1'h0;
    logic [1:0] rx_addr_top_i = 2'h0;
    logic [6:0] rx_addr_code_i = 7'h00, code = 7'h00;
    logic [7:0] addr_i = 8'h00, pec_rx_i = 8'h00, pec_calc_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, got, cfg = 32'h0;
    logic [15:0] lfsr = 16'h0045;
    wire [31:0] rdata_o;
    wire pec_nack_o, bus_limit_error_o, peripheral_enable_o;
    int fails = 0, samples_checked = 0;
    i2c_bus_partner bus_i ();
    i2c_bus_timeout_status i2c_bus_timeout_status_i (.clk_i, .rst_n_i,
        .ce_i(1'h1), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .scl_i(bus_i.scl), .sda_i(bus_i.sda), .alarm_pin_i(bus_i.alarm),
        .controller_mode_i, .stretching_i, .addr_match_i, .rx_addr_code_i,
        .ten_bit_i, .rx_addr_top_i, .rx_dir_i, .pec_check_i, .pec_rx_i,
        .pec_calc_i, .pec_nack_o, .bus_limit_error_o, .peripheral_enable_o);
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    function automatic logic [15:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr;
    endfunction
    // Flags f are busy, alert, timeout, PEC error
    function automatic logic [31:0] st(logic [3:0] f);
        return {8'h00, code, dir, f[3], 1'h0, f[2:0], 10'h000, 1'h1};
    endfunction
    // Guarded fields keep their value while their enable is stored
    function automatic logic [31:0] cfg_next(logic [31:0] n);
        return n & 32'h80008000 | (cfg[31] ? cfg : n) & 32'h0FFF0000
            | (cfg[15] ? cfg : n) & 32'h00001FFF;
    endfunction
    task automatic conclude();
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(logic [31:0] exp, logic [31:0] act);
        samples_checked++;
        if (act !== exp) begin
            fails++;
            $display("mismatch at %0t: %h expected, %h seen", $time, exp, act);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'h1;
        cyc(1);
        wr_i <= 1'h0;
        cyc(1);
    endtask
    task automatic wcfg(logic [31:0] d);
        wr(8'h14, d);
        cfg = cfg_next(d);
    endtask
    task automatic rd(logic [7:0] a);
        addr_i <= a;
        rd_i <= 1'h1;
        cyc(1);
        rd_i <= 1'h0;
        #1 got = rdata_o;
        cyc(1);
    endtask
    // Flag looked at just after the edge that launches it
    task automatic wait_tmo(int n);
        #1;
        repeat (n) if (bus_limit_error_o !== 1'h1) begin
            cyc(1);
            #1;
        end
        chk(32'h1, bus_limit_error_o);
        if (bus_limit_error_o !== 1'h1)
            conclude();
        cyc(1);
    endtask
    task automatic clr_tmo();
        wcfg(32'h0);
        wr(8'h1C, 32'h1000);
        chk(32'h0, bus_limit_error_o);
    endtask
    task automatic stretch(int n);
        stretching_i <= 1'h1;
        cyc(n);
        stretching_i <= 1'h0;
        cyc(5);
    endtask
    initial begin
        cyc(5);
        rst_n_i <= 1'h1;
        cyc(1);
        rd(8'h14);
        chk(32'h0, got);
        rd(8'h18);
        chk(st(4'h0), got);
        rd(8'h04);
        chk(32'h0, got);
        wr(8'h00, 32'h7);
        wcfg(32'h80059003);
        wcfg(32'h8FFF8FFF);
        rd(8'h14);
        chk(cfg, got);
        wcfg(32'h0);
        wcfg(32'h00009003);
        cyc(12);
        chk(32'h0, bus_limit_error_o);
        wait_tmo(20);
        clr_tmo();
        wcfg(32'h00008000);
        bus_i.hold_low(1900);
        cyc(1);
        chk(32'h0, bus_limit_error_o);
        bus_i.hold_low(2100);
        wait_tmo(10);
        clr_tmo();
        for (int m = 0; m < 2; m++) begin
            controller_mode_i <= m[0];
            wcfg(32'h80000000);
            stretch(1100);
            chk(32'h0, bus_limit_error_o);
            stretch(1100);
            wait_tmo(5);
            clr_tmo();
        end
        bus_i.start_cond();
        bus_i.alarm_pulse();
        cyc(8);
        rd(8'h18);
        chk(st(4'hC), got);
        wr(8'h1C, 32'h2000);
        bus_i.stop_cond();
        cyc(8);
        rd(8'h18);
        chk(st(4'h0), got);
        wr(8'h00, 32'h5);
        bus_i.alarm_pulse();
        cyc(8);
        rd(8'h18);
        chk(st(4'h0), got);
        wr(8'h00, 32'h7);
        for (int i = 0; i < 4; i++) begin
            got = {16'h0, rnd()};
            rx_addr_code_i <= got[6:0];
            ten_bit_i <= i[0];
            rx_addr_top_i <= got[8:7];
            rx_dir_i <= got[9];
            pec_rx_i <= got[15:8];
            pec_calc_i <= i[1] ? ~got[15:8] : got[15:8];
            addr_match_i <= 1'h1;
            pec_check_i <= 1'h1;
            code = i[0] ? {5'h1E, got[8:7]} : got[6:0];
            dir = got[9];
            cyc(1);
            addr_match_i <= 1'h0;
            pec_check_i <= 1'h0;
            #1 chk({31'h0, i[1]}, pec_nack_o);
            cyc(1);
            rd(8'h18);
            chk(st({3'h0, i[1]}), got);
            if (i < 3)
                wr(8'h1C, 32'h0800);
        end
        bus_i.start_cond();
        bus_i.alarm_pulse();
        cyc(8);
        wr(8'h00, 32'h0);
        rd(8'h18);
        chk(st(4'h0), got);
        bus_i.stop_cond();
        cyc(2);
        conclude();
    end
endmodule // i2c_bus_timeout_status_bench
